//--- wdps_pkg.sv
// constants for the watchdog with shared divider
package wdps_pkg;
  localparam int          CLK_HZ          = 20000000;
  localparam int          WD_PERIOD_MS    = 18;
  // 20 MHz * 18 ms = 360000 cycles, longest time rounds down
  localparam int          WD_PERIOD_CYC   = (CLK_HZ / 1000) * WD_PERIOD_MS;
  localparam int          WD_CNT_W        = 20;
  localparam int          DIV_W           = 8;
  localparam int          OPT_W           = 8;
  localparam logic [7:0]  OPT_RESET       = 8'h3F;
  localparam logic [7:0]  OPT_IMPL_MASK   = 8'h3F;
  localparam int          OPT_ASSIGN_BIT  = 3;
  localparam int          OPT_RATIO_LSB   = 0;
  localparam int          OPT_RATIO_W     = 3;
  localparam int          STATUS_TO_BIT   = 4;
  typedef enum logic [1:0] {
    WDPS_RST_NONE,
    WDPS_RST_DEVICE,
    WDPS_RST_WAKE
  } wdps_rst_kind_t;
endpackage

//--- wdps_divider.sv
// shared 8-bit divider, prescaler for the timer or postscaler for the watchdog
`timescale 1ns/10ps
module wdps_divider
  import wdps_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   clear,
  input  wire logic                   tick_in,
  input  wire logic [OPT_RATIO_W-1:0] ratio_sel,
  input  wire logic                   ratio_shift,
  output logic                        tick_out
);
  logic [DIV_W-1:0] count_r;
  logic [DIV_W-1:0] count_nxt;
  logic [3:0]       sel_bit;
  logic [DIV_W:0]   span_mask;

  always_comb begin
    count_nxt = count_r + 8'h01;
    sel_bit   = {1'b0, ratio_sel} + {3'h0, ratio_shift};
    span_mask = ({{DIV_W{1'b0}}, 1'b1} << sel_bit) - {{DIV_W{1'b0}}, 1'b1};
  end

  // one pulse per 2^sel_bit input ticks: the low sel_bit bits of the next
  // count wrap to zero; a zero span passes every tick, 1:256 needs all 8 bits
  always_comb begin
    tick_out = tick_in && ((count_nxt & span_mask[DIV_W-1:0]) == 8'h00);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 8'h00;
    end else if (clear) begin
      count_r <= 8'h00;
    end else if (tick_in) begin
      count_r <= count_nxt;
    end
  end
endmodule

//--- wdps_watchdog.sv
// watchdog timer with shared 8-bit divider
`timescale 1ns/10ps
module wdps_watchdog
  import wdps_pkg::*;
#(
  parameter int WD_PERIOD = WD_PERIOD_CYC
)
(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             watchdog_enable_fuse,
  input  wire logic             watchdog_clear_instr,
  input  wire logic             sleep_instr,
  input  wire logic             option_load_instr,
  input  wire logic [OPT_W-1:0] work_reg,
  input  wire logic             core_sleeping,
  input  wire logic             timer_tick,
  output logic                  timer_tick_out,
  output logic [OPT_W-1:0]      prescaler_option_reg,
  output logic                  device_reset_pulse,
  output logic                  wake_reset_pulse,
  output logic                  timeout_flag
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic       fuse_s;
  logic       clr_s;
  logic       slp_s;
  logic       optld_s;
  logic       sleeping_s;
  logic       tmr_s;

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end else begin
      pin_meta_r <= {watchdog_enable_fuse, watchdog_clear_instr, sleep_instr,
                     option_load_instr, core_sleeping, timer_tick};
      pin_sync_r <= pin_meta_r;
    end
  end

  always_comb begin
    {fuse_s, clr_s, slp_s, optld_s, sleeping_s, tmr_s} = pin_sync_r;
  end

  // ------------------------------------------------------------
  // option register
  // ------------------------------------------------------------
  logic [OPT_W-1:0] opt_r;
  logic             wd_reset_evt;
  logic             wd_owns_div;

  // watchdog reset reloads the option register like any reset
  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      opt_r <= OPT_RESET;
    end else if (wd_reset_evt) begin
      opt_r <= OPT_RESET;
    end else if (optld_s) begin
      opt_r <= work_reg & OPT_IMPL_MASK;
    end
  end

  always_comb begin
    wd_owns_div = opt_r[OPT_ASSIGN_BIT];
  end

  // ------------------------------------------------------------
  // base watchdog period counter
  // ------------------------------------------------------------
  // the on-chip oscillator is modelled by the free-running clock; this
  // keeps counting regardless of the core's sleep state
  logic [WD_CNT_W-1:0] wd_cnt_r;
  logic                wd_base_tick;
  logic                wd_active;
  logic                wd_restart;

  always_comb begin
    wd_active  = fuse_s;
    // a time-out is not a restart source here: it already wraps the count,
    // and feeding it back would close a loop through the divider
    wd_restart = clr_s || slp_s;
    wd_base_tick = wd_active && !wd_restart
                   && (wd_cnt_r == WD_CNT_W'(WD_PERIOD - 1));
  end

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wd_cnt_r <= '0;
    end else if (wd_restart || !wd_active || wd_base_tick) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // shared divider
  // ------------------------------------------------------------
  logic div_in;
  logic div_out;
  logic div_clear;

  // timer side gets ratio 2^(n+1), watchdog side 2^n
  always_comb begin
    div_in    = wd_owns_div ? wd_base_tick : tmr_s;
    // with the divider on the watchdog, a watchdog reset also empties it so the next span starts clean
    div_clear = wd_owns_div && (wd_restart || wd_reset_evt);
  end

  wdps_divider u_div (
    .clock       (clock),
    .rst_n       (rst_sync_r),
    .clear       (div_clear),
    .tick_in     (div_in),
    .ratio_sel   (opt_r[OPT_RATIO_LSB +: OPT_RATIO_W]),
    .ratio_shift (!wd_owns_div),
    .tick_out    (div_out)
  );

  logic wd_timeout;
  logic ratio_one;

  // ratio field zero with watchdog ownership means 1:1
  always_comb begin
    ratio_one  = (opt_r[OPT_RATIO_LSB +: OPT_RATIO_W] == 3'h0);
    wd_timeout = wd_owns_div ? (ratio_one ? wd_base_tick : div_out)
                             : wd_base_tick;
    wd_reset_evt = wd_timeout;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic tmr_out_r;
  logic dev_rst_r;
  logic wake_rst_r;
  logic to_flag_r;

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tmr_out_r <= 1'b0;
    end else begin
      tmr_out_r <= !wd_owns_div && div_out;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dev_rst_r  <= 1'b0;
      wake_rst_r <= 1'b0;
    end else begin
      dev_rst_r  <= wd_timeout && !sleeping_s;
      wake_rst_r <= wd_timeout && sleeping_s;
    end
  end

  // flag is set by reset and by the clear instruction, not by sleep; only a
  // watchdog time-out drops it, and the clear instruction sets it back
  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      to_flag_r <= 1'b1;
    end else if (wd_timeout) begin
      to_flag_r <= 1'b0;
    end else if (clr_s) begin
      to_flag_r <= 1'b1;
    end
  end

  always_comb begin
    timer_tick_out       = tmr_out_r;
    prescaler_option_reg = opt_r;
    device_reset_pulse   = dev_rst_r;
    wake_reset_pulse     = wake_rst_r;
    timeout_flag         = to_flag_r;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_timeout;
    wd_timeout;
  endsequence

  chk_reset_kind_device: assert property (@(posedge clock) disable iff (!rst_sync_r)
    s_timeout and !sleeping_s |=> dev_rst_r && !wake_rst_r)
    else $error("timeout awake did not give device reset");

  chk_reset_kind_wake: assert property (@(posedge clock) disable iff (!rst_sync_r)
    s_timeout and sleeping_s |=> wake_rst_r && !dev_rst_r)
    else $error("timeout asleep did not give wake reset");

  chk_flag_cleared: assert property (@(posedge clock) disable iff (!rst_sync_r)
    s_timeout |=> !to_flag_r)
    else $error("timeout flag not cleared");

  chk_fuse_off_quiet: assert property (@(posedge clock) disable iff (!rst_sync_r)
    !fuse_s |=> !dev_rst_r && !wake_rst_r && wd_cnt_r == '0)
    else $error("watchdog active with fuse off");

  chk_option_reset_val: assert property (@(posedge clock) disable iff (!rst_sync_r)
    s_timeout |=> opt_r == OPT_RESET)
    else $error("option not reloaded on watchdog reset");

  chk_option_load: assert property (@(posedge clock) disable iff (!rst_sync_r)
    optld_s && !wd_timeout |=> opt_r == ($past(work_reg) & OPT_IMPL_MASK))
    else $error("option load failed");

  chk_clear_restart: assert property (@(posedge clock) disable iff (!rst_sync_r)
    clr_s |=> wd_cnt_r == '0 && !dev_rst_r)
    else $error("clear did not restart watchdog");

  chk_sleep_restart: assert property (@(posedge clock) disable iff (!rst_sync_r)
    slp_s |=> wd_cnt_r == '0)
    else $error("sleep did not restart watchdog");

  chk_timer_no_wd: assert property (@(posedge clock) disable iff (!rst_sync_r)
    !wd_owns_div && wd_base_tick |=> dev_rst_r || wake_rst_r)
    else $error("watchdog divided while divider owned by timer");

  chk_base_period: assert property (@(posedge clock) disable iff (!rst_sync_r)
    wd_active && !wd_restart && !wd_base_tick |=> wd_cnt_r == $past(wd_cnt_r) + 1'b1)
    else $error("base period wrong");

  chk_timer_idle: assert property (@(posedge clock) disable iff (!rst_sync_r)
    wd_owns_div |=> !tmr_out_r)
    else $error("timer tick passed while divider on watchdog");

  chk_option_top_zero: assert property (@(posedge clock) disable iff (!rst_sync_r)
    (opt_r & ~OPT_IMPL_MASK) == 8'h00)
    else $error("unimplemented option bits set");

  chk_flag_set_clear: assert property (@(posedge clock) disable iff (!rst_sync_r)
    clr_s |=> to_flag_r)
    else $error("clear instruction did not set the time-out flag");

  chk_pulse_single: assert property (@(posedge clock) disable iff (!rst_sync_r)
    dev_rst_r || wake_rst_r |=> !dev_rst_r && !wake_rst_r)
    else $error("reset pulse longer than one cycle");

  // after either restart instruction no reset may follow for eight cycles,
  // which holds for any period of eight or more
  sequence s_restart_cmd;
    clr_s || slp_s;
  endsequence

  sequence s_quiet_run;
    (!dev_rst_r && !wake_rst_r) [*8];
  endsequence

  chk_restart_quiet: assert property (@(posedge clock) disable iff (!rst_sync_r)
    s_restart_cmd |=> s_quiet_run)
    else $error("reset pulse soon after restart");

  // base ticks since the last time-out, restart or option load; with the
  // divider on the watchdog a time-out must come within the selected span
  logic [DIV_W:0] chk_ticks_r;
  logic [DIV_W:0] chk_span;

  always_comb begin
    chk_span = {{DIV_W{1'b0}}, 1'b1} << opt_r[OPT_RATIO_LSB +: OPT_RATIO_W];
  end

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      chk_ticks_r <= '0;
    end else if (wd_restart || wd_reset_evt || optld_s || !wd_owns_div) begin
      chk_ticks_r <= '0;
    end else if (wd_base_tick) begin
      chk_ticks_r <= chk_ticks_r + 1'b1;
    end
  end

  chk_ratio_span: assert property (@(posedge clock) disable iff (!rst_sync_r)
    wd_owns_div |-> chk_ticks_r < chk_span)
    else $error("divided time-out later than selected ratio");
endmodule

//--- wdps_watchdog_tb.sv
// self-checking testbench for the watchdog with shared divider
`timescale 1ns/10ps
module wdps_watchdog_tb;
  import wdps_pkg::*;
  // ----------------------------------------
  // stimulus and clock
  // ----------------------------------------
  localparam int P = 20; // short period keeps the 1:128 case quick
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic             fuse = 1'b1;
  logic             clr_i = 1'b0;
  logic             slp_i = 1'b0;
  logic             ld_i = 1'b0;
  logic [OPT_W-1:0] work_reg = 8'h00;
  logic             sleeping = 1'b0;
  logic             tick = 1'b0;
  logic             tick_out;
  logic [OPT_W-1:0] opt;
  logic             dev_rst;
  logic             wake_rst;
  logic             to_flag;
  int               miscompares = 0;
  int               compares = 0;
  int               hits = 0;
  always #25 clock = ~clock;
  always @(posedge clock) if (dev_rst === 1'b1 || wake_rst === 1'b1) hits++;
  wdps_watchdog #(.WD_PERIOD(P)) u_wdps_watchdog (
    .clock(clock), .reset_n(reset_n), .watchdog_enable_fuse(fuse),
    .watchdog_clear_instr(clr_i), .sleep_instr(slp_i), .option_load_instr(ld_i),
    .work_reg(work_reg), .core_sleeping(sleeping), .timer_tick(tick),
    .timer_tick_out(tick_out), .prescaler_option_reg(opt),
    .device_reset_pulse(dev_rst), .wake_reset_pulse(wake_rst), .timeout_flag(to_flag));
  // ----------------------------------------
  // compare and drive helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic ld(input logic [7:0] v);
    @(negedge clock) begin work_reg = v; ld_i = 1'b1; end
    @(negedge clock) ld_i = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  task automatic clr();
    @(negedge clock) clr_i = 1'b1;
    @(negedge clock) clr_i = 1'b0;
  endtask
  // wait for a reset pulse and judge its moment and kind
  task automatic wait_to(input int lo, input int hi, input logic wake);
    int n;
    n = 0;
    while (dev_rst !== 1'b1 && wake_rst !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    chkn("timeout cycles", lo, hi, n);
    chk("wake pulse", {7'h00, wake}, {7'h00, wake_rst});
    chk("device pulse", {7'h00, !wake}, {7'h00, dev_rst});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("option", 8'h3F, opt);
    chk("flag", 8'h01, {7'h00, to_flag});
    $display("test reset done");
  endtask
  task automatic t_load();
    ld(8'h0F);
    chk("option", 8'h0F, opt);
    ld(8'hFF);
    chk("option", 8'h3F, opt);
    $display("test load done");
  endtask
  task automatic t_plain();
    ld(8'h00);
    clr();
    wait_to(P - 1, P + 9, 1'b0);
    chk("flag", 8'h00, {7'h00, to_flag});
    chk("option", 8'h3F, opt);
    clr();
    repeat (4) @(negedge clock);
    chk("flag", 8'h01, {7'h00, to_flag});
    $display("test plain timeout done");
  endtask
  task automatic t_ratio();
    for (int r = 0; r < 8; r++) begin
      ld(8'h08 | r[7:0]);
      clr();
      wait_to((P << r) - 1, (P << r) + (1 << r) + 8, 1'b0);
    end
    $display("test ratios done");
  endtask
  task automatic t_clear();
    ld(8'h08);
    hits = 0;
    repeat (10) begin
      clr();
      repeat (12) @(negedge clock);
    end
    chkn("pulses while cleared", 0, 0, hits);
    $display("test clear done");
  endtask
  task automatic t_sleep();
    ld(8'h08);
    // restart first so the sleep lands mid-period, not after a stray time-out
    clr();
    repeat (P / 2) @(negedge clock);
    @(negedge clock) begin sleeping = 1'b1; slp_i = 1'b1; end
    @(negedge clock) slp_i = 1'b0;
    wait_to(P - 1, P + 9, 1'b1);
    @(negedge clock) sleeping = 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_timer(input logic [7:0] v, input int lo, input int hi);
    int n;
    n = 0;
    ld(v);
    @(negedge clock) tick = 1'b1;
    repeat (64) begin
      @(negedge clock);
      if (tick_out === 1'b1) n++;
    end
    @(negedge clock) tick = 1'b0;
    chkn("timer ticks", lo, hi, n);
  endtask
  task automatic t_fuse();
    @(negedge clock) fuse = 1'b0;
    repeat (4) @(negedge clock);
    hits = 0;
    t_timer(8'h00, 31, 33);
    t_timer(8'h02, 7, 9);
    repeat (2 * P) @(negedge clock);
    chkn("pulses with fuse off", 0, 0, hits);
    @(negedge clock) fuse = 1'b1;
    $display("test fuse and timer done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset();
    t_load();
    t_plain();
    t_ratio();
    t_clear();
    t_sleep();
    t_fuse();
    give_verdict();
  end
  // whole run is about 5600 cycles; allow well over twice that
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
endmodule
